// ==== src/dtfl_pkg.sv ====
package dtfl_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int NUM_IN          = 4;          // Digital input terminals
  localparam int NUM_OUT         = 4;          // Output terminals
  localparam int NUM_FL          = 6;          // Status functions 0 to 5
  localparam int CLK_HZ          = 10_000_000;
  localparam int HOLD_TIME_MS    = 100;        // Analog hold settle time
  localparam int HOLD_CYCLES_DEF = HOLD_TIME_MS * (CLK_HZ / 1000);
  localparam int HOLD_CW         = 24;         // Hold counter width

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_IN_SEL = 8'h04;
  localparam logic [7:0] ADDR_OUTSEL = 8'h08;
  localparam logic [7:0] ADDR_OFS1   = 8'h0C;
  localparam logic [7:0] ADDR_OFS2   = 8'h10;
  localparam logic [7:0] ADDR_OFS3   = 8'h14;
  localparam logic [7:0] ADDR_ZERO   = 8'h18;
  localparam logic [7:0] ADDR_DET    = 8'h1C;
  localparam logic [7:0] ADDR_UV     = 8'h20;
  localparam logic [7:0] ADDR_FCMD   = 8'h24;
  localparam logic [7:0] ADDR_STAT   = 8'h28;
  localparam logic [7:0] ADDR_ACT    = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_CLV      = 0;            // Closed-loop vector mode
  localparam int CTRL_SRC_ANA  = 1;            // Command from analog
  localparam int CTRL_ANA_SEL  = 2;            // 0 first, 1 second input
  localparam int CTRL_STOP_LSB = 4;            // Stopping method, 2 bits
  localparam logic [7:0]  IN_CODE_NONE = 8'hFF;
  localparam logic [7:0]  OUT_SEL_RST  = 8'h00;
  localparam logic [7:0]  OUT_CODE_MAX = 8'h95; // 149
  localparam logic [7:0]  OUT_INV_BASE = 8'h64; // 100
  localparam logic [15:0] FREQ_RST     = 16'h0000;

  // ----------------------------------------------------------------
  // Input function codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FN_UPDN_UP   = 8'h0A;  // 10
  localparam logic [7:0] FN_UP2_DN2   = 8'h0D;  // 13, top of 10..13
  localparam logic [7:0] FN_RAMP_HOLD = 8'h12;  // 18
  localparam logic [7:0] FN_OFS1      = 8'h35;  // 53
  localparam logic [7:0] FN_OFS3      = 8'h37;  // 55
  localparam logic [7:0] FN_LOCKOUT   = 8'h3C;  // 60
  localparam logic [7:0] FN_ANA_HOLD  = 8'h3D;  // 61
  localparam logic [7:0] FN_DC_BRAKE  = 8'h41;  // 65
  localparam logic [7:0] FN_ENABLE    = 8'h45;  // 69

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RG_STOP, RG_RUN, RG_BLOCK} dtfl_rg_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dtfl_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dtfl_apb_rsp_s;

  typedef struct packed {
    logic        run_cmd;
    logic        jog_cmd;
    logic        decel;
    logic        outputting;
    logic        fault;
    logic        psu_fail;
    logic        param_invalid;
    logic        prog_mode;
    logic        ov_uv_fault;
    logic        power_loss;
    logic [15:0] out_freq;
    logic [15:0] motor_speed;
    logic [15:0] dc_bus;
    logic [15:0] analog_input_one;
    logic [15:0] analog_input_two;
  } dtfl_core_s;

  typedef struct packed {
    logic [15:0] freq_cmd;
    logic        run_permit;
    logic        enable_stop;
    logic [1:0]  stopping_method_selection;
    logic        dc_brake;
    logic        drive_not_enabled_display;
    logic        setting_conflict_error;
  } dtfl_drv_s;

  // ----------------------------------------------------------------
  // Arithmetic helpers on signed frequency words
  // ----------------------------------------------------------------
  function automatic logic [15:0] f_abs(input logic [15:0] v);
    f_abs = v[15] ? 16'(-v) : v;
  endfunction : f_abs

  // True when the magnitudes of a and b differ by at most w
  function automatic logic f_near(input logic [15:0] a,
                                  input logic [15:0] b,
                                  input logic [15:0] w);
    logic [16:0] d;
    d = {1'b0, f_abs(a)} - {1'b0, f_abs(b)};
    f_near = (d[16] ? 17'(-d) : d) <= {1'b0, w};
  endfunction : f_near

  // Saturate an 18-bit signed sum to 16 bits
  function automatic logic [15:0] f_sat(input logic [17:0] s);
    if (s[17] && !(&s[16:15]))
      f_sat = 16'h8000;
    else if (!s[17] && (|s[16:15]))
      f_sat = 16'h7FFF;
    else
      f_sat = s[15:0];
  endfunction : f_sat

endpackage : dtfl_pkg

// ==== src/dtfl_sync.sv ====
`timescale 1ns/1ns
module dtfl_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  // Pin side and synchronised side
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dtfl_sync_s;

  dtfl_sync_s st_ff;
  dtfl_sync_s nxt_ff;

  // Stage one feeds stage two only
  always_comb
  begin
    nxt_ff    = st_ff;
    nxt_ff.s1 = d;
    nxt_ff.s2 = st_ff.s1;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      st_ff <= '0;
    else if (clk_en)
      st_ff <= nxt_ff;
  end

  assign q = st_ff.s2;
endmodule : dtfl_sync

// ==== src/dtfl_outsel.sv ====
`timescale 1ns/1ns
module dtfl_outsel
  import dtfl_pkg::*;
(
  // Selection code of one output terminal
  input  wire logic [7:0]        code,
  // Levels of status functions 0 to 5
  input  wire logic [NUM_FL-1:0] fl,
  // Terminal level, high means closed
  output      logic              lvl
);
  logic [7:0] base;
  logic       inv;

  // Codes 100..149 mirror 0..49 inverted; unknown codes stay open
  always_comb
  begin
    inv  = (code >= OUT_INV_BASE) && (code <= OUT_CODE_MAX);
    base = inv ? 8'(code - OUT_INV_BASE) : code;
    if (base < 8'(NUM_FL))
      lvl = fl[base[2:0]] ^ inv;
    else
      lvl = 1'b0;
  end
endmodule : dtfl_outsel

// ==== src/dtfl_top.sv ====
// Notes on behaviour
// - Closed offset terminals 53/54/55 add offsets one to three to the command.
// - Lockout 60 open blocks writes except command monitor; reads always work.
// - Hold 61 closed for 100ms samples the analog command and holds it.
// - Power loss clears the held analog command to zero.
// - Hold with ramp hold, up/down, offset or up2/down2 flags a conflict.
// - Brake 65 applies DC braking in deceleration; run or jog releases it.
// - Enable 69 open ignores run and shows the not-enabled display.
// - Run present when enable closes needs removal and reapply to start.
// - Enable opening during run stops using the selected stopping method.
// - Four output selects accept codes 0 to 149; first relay defaults 0.
// - Codes 100 to 149 output the inverse of the code 100 lower.
// - Code 0 closes while voltage is output, opens while stopped.
// - Code 1 closes while output frequency is below the zero threshold.
// - Zero threshold is hold start level in closed loop, else minimum.
// - Code 2 closes when output matches command within width, either way.
// - Closed-loop code 2 compares measured motor speed instead.
// - Code 3 closes when output and command both sit near the level.
// - Code 4 closes while ready to run or running.
// - Loss, fault, supply, bad setting, stopped ov/uv, programming: not ready.
// - Code 5 closes while bus voltage is under the undervoltage level.
`timescale 1ns/1ns
module dtfl_top
  import dtfl_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  // Clock, reset and freeze
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  // Register bus
  input  wire dtfl_pkg::dtfl_apb_req_s apb_req,
  output      dtfl_pkg::dtfl_apb_rsp_s apb_rsp,
  // Input terminal pins, high means closed
  input  wire logic [dtfl_pkg::NUM_IN-1:0]  term_in,
  // Drive core status on this clock
  input  wire dtfl_pkg::dtfl_core_s   core,
  // Drive core controls
  output      dtfl_pkg::dtfl_drv_s    drv,
  // Output terminals, high means closed
  output      logic [dtfl_pkg::NUM_OUT-1:0] out_term
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [HOLD_CW-1:0] HOLD_LAST = HOLD_CW'(HOLD_CYCLES - 1);
  localparam logic [HOLD_CW-1:0] HOLD_FULL = HOLD_CW'(HOLD_CYCLES);

  typedef struct packed {
    dtfl_apb_rsp_s                rsp;
    dtfl_drv_s                    drv;
    logic                         clv;
    logic                         src_ana;
    logic                         ana_sel;
    logic [1:0]                   stop_meth;
    logic [NUM_IN-1:0][7:0]       in_sel;
    logic [NUM_OUT-1:0][7:0]      out_sel;
    logic [2:0][15:0]             ofs;
    logic [15:0]                  minimum_output_frequency;
    logic [15:0]                  zero_speed_hold_start_level;
    logic [15:0]                  frequency_detection_level;
    logic [15:0]                  frequency_detection_width;
    logic [15:0]                  undervoltage_detect_level;
    logic [15:0]                  frequency_command_monitor;
    logic [HOLD_CW-1:0]           hold_cnt;
    logic [15:0]                  hold_val;
    dtfl_rg_e                     rg;
    logic [NUM_OUT-1:0]           out_term;
  } dtfl_st_s;

  dtfl_st_s st_ff;
  dtfl_st_s nxt_ff;

  // ----------------------------------------------------------------
  // Terminal synchroniser
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] term;

  // Pins are asynchronous to clk, so two stages before use
  dtfl_sync #(
    .W       (NUM_IN)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .d       (term_in),
    .q       (term)
  );

  // ----------------------------------------------------------------
  // Input function decode per terminal
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] fn_ofs1;
  logic [NUM_IN-1:0] fn_ofs2;
  logic [NUM_IN-1:0] fn_ofs3;
  logic [NUM_IN-1:0] fn_lock;
  logic [NUM_IN-1:0] fn_hold;
  logic [NUM_IN-1:0] fn_brk;
  logic [NUM_IN-1:0] fn_en;
  logic [NUM_IN-1:0] fn_cfl;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++)
    begin : g_in
      // Each terminal carries one function code
      assign fn_ofs1[gi] = st_ff.in_sel[gi] == FN_OFS1;
      assign fn_ofs2[gi] = st_ff.in_sel[gi] == 8'(FN_OFS1 + 8'h01);
      assign fn_ofs3[gi] = st_ff.in_sel[gi] == FN_OFS3;
      assign fn_lock[gi] = st_ff.in_sel[gi] == FN_LOCKOUT;
      assign fn_hold[gi] = st_ff.in_sel[gi] == FN_ANA_HOLD;
      assign fn_brk[gi]  = st_ff.in_sel[gi] == FN_DC_BRAKE;
      assign fn_en[gi]   = st_ff.in_sel[gi] == FN_ENABLE;
      // Functions that fight the analog hold
      assign fn_cfl[gi]  = (st_ff.in_sel[gi] == FN_RAMP_HOLD)
                         | ((st_ff.in_sel[gi] >= FN_UPDN_UP)
                           & (st_ff.in_sel[gi] <= FN_UP2_DN2))
                         | ((st_ff.in_sel[gi] >= FN_OFS1)
                           & (st_ff.in_sel[gi] <= FN_OFS3));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Terminal summaries
  // ----------------------------------------------------------------
  logic locked;
  logic hold_on;
  logic hold_used;
  logic brk_on;
  logic en_used;
  logic enabled;

  // An unassigned function never blocks anything
  assign locked    = |(fn_lock & ~term);
  assign hold_used = |fn_hold;
  assign hold_on   = |(fn_hold & term);
  assign brk_on    = |(fn_brk & term);
  assign en_used   = |fn_en;
  assign enabled   = !en_used || (|(fn_en & term));

  // ----------------------------------------------------------------
  // Frequency command path
  // ----------------------------------------------------------------
  logic [15:0] ana_live;
  logic [15:0] base_cmd;
  logic [17:0] cmd_sum;

  // Hold mode runs from the held word, which reads zero after reset
  always_comb
  begin
    ana_live = st_ff.ana_sel ? core.analog_input_two : core.analog_input_one;
    if (!st_ff.src_ana)
      base_cmd = st_ff.frequency_command_monitor;
    else if (hold_used)
      base_cmd = st_ff.hold_val;
    else
      base_cmd = ana_live;
    cmd_sum = {{2{base_cmd[15]}}, base_cmd};
    if (|(fn_ofs1 & term))
      cmd_sum = cmd_sum + {{2{st_ff.ofs[0][15]}}, st_ff.ofs[0]};
    if (|(fn_ofs2 & term))
      cmd_sum = cmd_sum + {{2{st_ff.ofs[1][15]}}, st_ff.ofs[1]};
    if (|(fn_ofs3 & term))
      cmd_sum = cmd_sum + {{2{st_ff.ofs[2][15]}}, st_ff.ofs[2]};
  end

  // ----------------------------------------------------------------
  // Status functions for the output terminals
  // ----------------------------------------------------------------
  logic [NUM_FL-1:0] fl;
  logic [15:0]       zero_thr;
  logic [15:0]       spd;
  logic              not_ready;

  always_comb
  begin
    zero_thr = st_ff.clv ? st_ff.zero_speed_hold_start_level
                         : st_ff.minimum_output_frequency;
    spd      = st_ff.clv ? core.motor_speed : core.out_freq;
    // A pending conflict counts as a setting the drive cannot run with
    not_ready = core.power_loss | core.fault | core.psu_fail
              | core.param_invalid | st_ff.drv.setting_conflict_error
              | (core.ov_uv_fault & !core.outputting)
              | core.prog_mode;
    fl[0] = core.outputting;
    fl[1] = f_abs(core.out_freq) < zero_thr;
    fl[2] = f_near(spd, st_ff.drv.freq_cmd,
                   st_ff.frequency_detection_width);
    fl[3] = f_near(core.out_freq, st_ff.frequency_detection_level,
                   st_ff.frequency_detection_width)
          & f_near(st_ff.drv.freq_cmd, st_ff.frequency_detection_level,
                   st_ff.frequency_detection_width);
    fl[4] = !not_ready;
    fl[5] = core.dc_bus < st_ff.undervoltage_detect_level;
  end

  logic [NUM_OUT-1:0] lvl;

  genvar go;
  generate
    for (go = 0; go < NUM_OUT; go++)
    begin : g_out
      // One selector per output terminal
      dtfl_outsel u_sel (
        .code (st_ff.out_sel[go]),
        .fl   (fl),
        .lvl  (lvl[go])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr_go;
  logic        mapped;
  logic        wr_ok;
  logic [31:0] rd_data;

  // Answer registered in setup, so every access has zero wait states
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_go = apb_req.psel && apb_req.penable && st_ff.rsp.pready
              && apb_req.pwrite;
  // Reads never depend on the lockout terminal
  assign wr_ok = !locked || (apb_req.paddr == ADDR_FCMD);

  always_comb
  begin
    mapped  = 1'b1;
    rd_data = 32'h0000_0000;
    case (apb_req.paddr)
      ADDR_CTRL:
        rd_data = {26'h0, st_ff.stop_meth, 1'b0, st_ff.ana_sel,
                   st_ff.src_ana, st_ff.clv};
      ADDR_IN_SEL: rd_data = st_ff.in_sel;
      ADDR_OUTSEL: rd_data = st_ff.out_sel;
      ADDR_OFS1:   rd_data = {16'h0, st_ff.ofs[0]};
      ADDR_OFS2:   rd_data = {16'h0, st_ff.ofs[1]};
      ADDR_OFS3:   rd_data = {16'h0, st_ff.ofs[2]};
      ADDR_ZERO:
        rd_data = {st_ff.zero_speed_hold_start_level,
                   st_ff.minimum_output_frequency};
      ADDR_DET:
        rd_data = {st_ff.frequency_detection_width,
                   st_ff.frequency_detection_level};
      ADDR_UV:     rd_data = {16'h0, st_ff.undervoltage_detect_level};
      ADDR_FCMD:   rd_data = {16'h0, st_ff.frequency_command_monitor};
      ADDR_STAT:
        rd_data = {17'h0, st_ff.rg, locked, st_ff.drv.run_permit,
                   st_ff.drv.dc_brake,
                   st_ff.drv.drive_not_enabled_display,
                   st_ff.drv.setting_conflict_error, term, st_ff.out_term};
      ADDR_ACT:    rd_data = {16'h0, st_ff.drv.freq_cmd};
      default:     mapped  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_ff = st_ff;

    // Bus answer: ready for one cycle, error on unmapped or locked write
    nxt_ff.rsp.pready  = setup;
    nxt_ff.rsp.pslverr = setup && (!mapped || (apb_req.pwrite && !wr_ok));
    nxt_ff.rsp.prdata  = (setup && !apb_req.pwrite) ? rd_data : 32'h0;

    // Register writes take effect only at the completing edge
    if (wr_go && wr_ok)
    begin
      case (apb_req.paddr)
        ADDR_CTRL:
        begin
          nxt_ff.clv       = apb_req.pwdata[CTRL_CLV];
          nxt_ff.src_ana   = apb_req.pwdata[CTRL_SRC_ANA];
          nxt_ff.ana_sel   = apb_req.pwdata[CTRL_ANA_SEL];
          nxt_ff.stop_meth = apb_req.pwdata[CTRL_STOP_LSB +: 2];
        end
        ADDR_IN_SEL: nxt_ff.in_sel = apb_req.pwdata;
        ADDR_OUTSEL:
        begin
          // A byte above the top code is dropped, others still land
          for (int k = 0; k < NUM_OUT; k++)
          begin
            if (apb_req.pwdata[8*k +: 8] <= OUT_CODE_MAX)
              nxt_ff.out_sel[k] = apb_req.pwdata[8*k +: 8];
          end
        end
        ADDR_OFS1: nxt_ff.ofs[0] = apb_req.pwdata[15:0];
        ADDR_OFS2: nxt_ff.ofs[1] = apb_req.pwdata[15:0];
        ADDR_OFS3: nxt_ff.ofs[2] = apb_req.pwdata[15:0];
        ADDR_ZERO:
        begin
          nxt_ff.minimum_output_frequency    = apb_req.pwdata[15:0];
          nxt_ff.zero_speed_hold_start_level = apb_req.pwdata[31:16];
        end
        ADDR_DET:
        begin
          nxt_ff.frequency_detection_level = apb_req.pwdata[15:0];
          nxt_ff.frequency_detection_width = apb_req.pwdata[31:16];
        end
        ADDR_UV:   nxt_ff.undervoltage_detect_level = apb_req.pwdata[15:0];
        ADDR_FCMD: nxt_ff.frequency_command_monitor = apb_req.pwdata[15:0];
        // Status, active command and unmapped words change nothing
        default:   ;
      endcase
    end

    // Analog hold: count closed time, sample once on the last cycle
    if (hold_on)
    begin
      if (st_ff.hold_cnt != HOLD_FULL)
        nxt_ff.hold_cnt = HOLD_CW'(st_ff.hold_cnt + 1'b1);
      if (st_ff.hold_cnt == HOLD_LAST)
        nxt_ff.hold_val = ana_live;
    end
    else
    begin
      nxt_ff.hold_cnt = '0;
    end
    // Power loss wins over a sample taken in the same cycle
    if (core.power_loss)
    begin
      nxt_ff.hold_val = FREQ_RST;
      nxt_ff.hold_cnt = '0;
    end

    // Run gate for the enable terminal
    nxt_ff.drv.enable_stop = 1'b0;
    case (st_ff.rg)
      RG_STOP:
        if (core.run_cmd)
          nxt_ff.rg = enabled ? RG_RUN : RG_BLOCK;
      RG_RUN:
        if (!core.run_cmd)
          nxt_ff.rg = RG_STOP;
        else if (!enabled)
        begin
          nxt_ff.rg              = RG_BLOCK;
          nxt_ff.drv.enable_stop = 1'b1;
        end
      RG_BLOCK:
        // Only removal of run leaves here, so run must be cycled
        if (!core.run_cmd)
          nxt_ff.rg = RG_STOP;
      default:
        nxt_ff.rg = RG_STOP;
    endcase

    // Registered drive controls
    nxt_ff.drv.run_permit = (nxt_ff.rg == RG_RUN);
    nxt_ff.drv.stopping_method_selection = st_ff.stop_meth;
    nxt_ff.drv.drive_not_enabled_display = en_used && !enabled;
    nxt_ff.drv.setting_conflict_error = hold_used && (|fn_cfl);
    nxt_ff.drv.dc_brake = brk_on && core.decel
                       && !(core.run_cmd || core.jog_cmd);
    nxt_ff.drv.freq_cmd = f_sat(cmd_sum);
    nxt_ff.out_term     = lvl;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Input codes reset to unassigned so no function is live at start
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_ff            <= '0;
      st_ff.in_sel     <= {NUM_IN{IN_CODE_NONE}};
      st_ff.out_sel    <= {NUM_OUT{OUT_SEL_RST}};
      st_ff.hold_val   <= FREQ_RST;
      st_ff.rg         <= RG_STOP;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign apb_rsp  = st_ff.rsp;
  assign drv      = st_ff.drv;
  assign out_term = st_ff.out_term;

endmodule : dtfl_top

// ==== dv/dtfl_chk.sv ====
`timescale 1ns/1ns
module dtfl_chk
  import dtfl_pkg::*;
(
  input wire logic          clk,
  input wire logic          reset_n,
  input wire dtfl_apb_req_s apb_req,
  input wire dtfl_apb_rsp_s apb_rsp,
  input wire dtfl_core_s    core,
  input wire dtfl_drv_s     drv,
  input wire logic [3:0]    out_term
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_SETUP_ANS: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no answer");
  AST_RDY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("long ready");
  AST_ERR_READY: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("error without ready");
  AST_RST_QUIET: assert property ($rose(reset_n) |-> out_term == 4'h0 && drv == '0)
    else $error("reset value");
  AST_FCMD_OPEN: assert property (apb_req.psel && apb_req.paddr == ADDR_FCMD |=>
    !apb_rsp.pslverr) else $error("monitor refused");
  AST_DNE_GATE: assert property (drv.drive_not_enabled_display |-> !drv.run_permit)
    else $error("run while not enabled");
  AST_RUN_CAUSE: assert property ($rose(drv.run_permit) |-> $past(core.run_cmd))
    else $error("run without command");
  AST_EN_STOP: assert property (drv.enable_stop |-> !drv.run_permit ##1 !drv.enable_stop)
    else $error("enable stop");
  AST_BRK_WHY: assert property (drv.dc_brake |-> $past(core.decel && !core.run_cmd))
    else $error("brake cause");
  AST_BRK_OFF: assert property (core.run_cmd || core.jog_cmd |=> !drv.dc_brake)
    else $error("brake kept");
  cover property (drv.enable_stop);
  cover property (drv.dc_brake);
  cover property (drv.setting_conflict_error);
endmodule : dtfl_chk
bind dtfl_top dtfl_chk u_dtfl_chk (.clk(clk), .reset_n(reset_n), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .core(core), .drv(drv), .out_term(out_term));

// ==== dv/dtfl_switch_model.sv ====
`timescale 1ns/1ns
// Contacts settle one clock after the wanted pattern changes
module dtfl_switch_model (
  input  wire logic       clk,
  input  wire logic [3:0] want,
  output      logic [3:0] term_in
);
  always_ff @(posedge clk) term_in <= want;
endmodule : dtfl_switch_model

// ==== dv/dtfl_top_test.sv ====
`timescale 1ns/1ns
module dtfl_top_test;
  import dtfl_pkg::*;
  logic clk, reset_n;
  dtfl_apb_req_s req;
  dtfl_apb_rsp_s rsp;
  dtfl_core_s core;
  dtfl_drv_s drv;
  logic [3:0] want, term_in, out_term;
  int bad_count, comparisons, cycles;
  dtfl_top #(.HOLD_CYCLES(8)) u_dtfl_top (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
    .apb_req(req), .apb_rsp(rsp), .term_in(term_in), .core(core), .drv(drv),
    .out_term(out_term));
  dtfl_switch_model u_dtfl_switch_model (.clk(clk), .want(want), .term_in(term_in));
  task close_out;
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin bad_count++; $display("unexpected at %0t: %h not %h", $time, g, x); end
  endtask : chk
  // One APB transfer; read data and error flag compared at the ready edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk) req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    chk(rsp.pslverr, e);
    if (!w) chk(rsp.prdata, d);
  endtask : bus
  // Model, two sync stages and the output register, then one edge to read it
  task settle;
    repeat (5) @(posedge clk);
  endtask : settle
  initial begin clk = 0; forever #50 clk = ~clk; end
  // Hang guard well beyond the roughly 150 cycles of the run
  always @(posedge clk) begin cycles++; if (cycles == 3000) begin bad_count++; close_out(); end end
  initial begin
    reset_n = 0; req = '0; core = '0; want = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk) chk(out_term, 0);
    bus(0, ADDR_OUTSEL, 0, 0);
    bus(1, ADDR_UV, 32'h200, 0);
    bus(1, ADDR_OUTSEL, 32'h31056400, 0);
    core.dc_bus <= 16'h0100;
    core.outputting <= 1'b1;
    settle();
    chk(out_term, 4'h5);
    core.outputting <= 1'b0;
    settle();
    chk(out_term, 4'h6);
    bus(1, ADDR_ZERO, 32'h10, 0);
    bus(1, ADDR_OUTSEL, 32'h96680401, 0);
    bus(0, ADDR_OUTSEL, 32'h31680401, 0);
    settle();
    chk(out_term, 4'h3);
    core.fault <= 1'b1;
    settle();
    chk(out_term, 4'h5);
    core.fault <= 1'b0;
    want <= 4'h1;
    bus(1, ADDR_IN_SEL, 32'h3D45413C, 0);
    want <= 4'h0;
    settle();
    bus(1, ADDR_OFS1, 5, 1);
    bus(0, ADDR_OFS1, 0, 0);
    bus(1, ADDR_FCMD, 32'h300, 0);
    want <= 4'h1;
    core.run_cmd <= 1'b1;
    settle();
    chk({drv.run_permit, drv.drive_not_enabled_display}, 1);
    want <= 4'h5;
    settle();
    chk(drv.run_permit, 0);
    core.run_cmd <= 1'b0;
    @(posedge clk) core.run_cmd <= 1'b1;
    settle();
    chk(drv.run_permit, 1);
    want <= 4'h3;
    settle();
    chk({drv.run_permit, drv.enable_stop}, 1);
    core.run_cmd <= 1'b0;
    core.decel <= 1'b1;
    settle();
    chk(drv.dc_brake, 1);
    core.jog_cmd <= 1'b1;
    repeat (2) @(posedge clk);
    chk(drv.dc_brake, 0);
    bus(1, ADDR_CTRL, 32'h22, 0);
    core.analog_input_one <= 16'h0123;
    want <= 4'h9;
    repeat (12) @(posedge clk);
    chk(drv.freq_cmd, 0);
    @(posedge clk);
    chk(drv.freq_cmd, 16'h0123);
    chk(drv.stopping_method_selection, 2);
    core.power_loss <= 1'b1;
    repeat (3) @(posedge clk);
    chk(drv.freq_cmd, 0);
    core.power_loss <= 1'b0;
    bus(1, ADDR_CTRL, 0, 0);
    bus(1, ADDR_OFS1, 32'h40, 0);
    bus(1, ADDR_IN_SEL, 32'h353D413C, 0);
    settle();
    chk(drv.setting_conflict_error, 1);
    chk(drv.freq_cmd, 16'h0340);
    bus(1, ADDR_DET, 32'h00100340, 0);
    bus(1, ADDR_ZERO, 32'h04000010, 0);
    bus(1, ADDR_OUTSEL, 32'h01660302, 0);
    core.out_freq <= 16'hFCBB;
    settle();
    chk(out_term, 4'h3);
    bus(1, ADDR_CTRL, 1, 0);
    settle();
    chk(out_term, 4'hE);
    bus(1, 8'h40, 1, 1);
    bus(0, 8'h40, 0, 1);
    close_out();
  end
endmodule : dtfl_top_test
